// ---- hdl/clk_cfg.svh ----
`ifndef CLK_CFG_SVH
`define CLK_CFG_SVH

// Register byte addresses
`define CLK_DIVISOR_ADDR    4'h0
`define FB_DIVISOR_ADDR     4'h4
`define TUNING_ADDR         4'h8
`define STATUS_ADDR         4'hC

// Clock divisor register fields
`define CLK_DIV_RECOVER_BIT 15
`define CLK_DIV_RATIO_HI    14
`define CLK_DIV_RATIO_LO    12
`define CLK_DIV_EN_BIT      11
`define CLK_DIV_RATIO_RST   3'h3

// Feedback divisor fields
`define FB_DIV_MULT_W       9
`define FB_DIV_MULT_RST     9'h030

// Tuning fields
`define TUNING_W           6
`define TUNING_RST         6'h00

`endif

// ---- hdl/clk_pkg.sv ----
package clk_pkg;
    typedef logic [2:0] ratio_sel_t;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;
endpackage : clk_pkg

// ---- hdl/cpu_clk_div.sv ----
`timescale 1ns/100ps
// Divides the processor clock enable by 2^sel while enabled
module cpu_clk_div
    import clk_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       enable_i,
    input  wire ratio_sel_t sel_i,
    // Output
    output logic            cpu_tick_o
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    function automatic logic [6:0] limit(input ratio_sel_t s);
        limit = 7'((8'h01 << s) - 8'h01);
    endfunction : limit

    always_comb begin
        cnt_d  = cnt_q + 7'h01;
        tick_d = 1'b0;
        if (!enable_i || cnt_q >= limit(sel_i)) begin
            cnt_d  = 7'h00;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign cpu_tick_o = tick_q;

    AST_FULL_SPEED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !enable_i |=> cpu_tick_o)
        else $error("tick missing while ratio disabled");
endmodule : cpu_clk_div

// ---- hdl/clk_ctrl.sv ----
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/100ps
`include "clk_cfg.svh"
// Overview of operation
// - Interrupt with recover set clears ratio enable
// - Divisor register resets only on power-on
// - Ratio select writes ignored while enabled
// - Enable cannot set while select is 000
// - Feedback register resets only on power-on
// - Nine-bit multiplier, default 48, upper zero
module clk_ctrl
    import clk_pkg::*;
(
    // Clock and resets
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        other_rst_n_i,
    // Avalon-MM slave
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // Events and clock outputs
    input  wire logic        irq_event_i,
    output logic             cpu_tick_o,
    output logic             periph_tick_o,
    output logic [8:0]       pll_mult_o,
    output logic [5:0]       rc_osc_trim_o
);
    // rst_n_i is power-on reset; other_rst_n_i is any other reset source
    bus_state_t  st_q;
    bus_state_t  st_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        recover_q;
    logic        recover_d;
    ratio_sel_t  ratio_q;
    ratio_sel_t  ratio_d;
    logic        ratio_en_q;
    logic        ratio_en_d;
    logic [`FB_DIV_MULT_W-1:0] mult_q;
    logic [`FB_DIV_MULT_W-1:0] mult_d;
    logic [`TUNING_W-1:0]      trim_q;
    logic [`TUNING_W-1:0]      trim_d;
    logic        wr_hit;
    logic [15:0] wlo;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    // Writes commit at the edge where the master sees waitrequest low
    assign wr_hit = write_i && (st_q == BUS_ACK);
    assign wlo    = writedata_i[15:0];

    always_comb begin
        recover_d  = recover_q;
        ratio_d    = ratio_q;
        ratio_en_d = ratio_en_q;
        mult_d     = mult_q;
        trim_d     = trim_q;
        if (wr_hit && hit(address_i, `CLK_DIVISOR_ADDR) && byteenable_i[1]) begin
            recover_d = wlo[`CLK_DIV_RECOVER_BIT];
            if (!ratio_en_q) begin
                ratio_d = wlo[`CLK_DIV_RATIO_HI:`CLK_DIV_RATIO_LO];
            end
            if (ratio_q != 3'h0) begin
                ratio_en_d = wlo[`CLK_DIV_EN_BIT];
            end else begin
                ratio_en_d = 1'b0;
            end
        end
        if (recover_q && irq_event_i) begin
            ratio_en_d = 1'b0;
        end
        if (wr_hit && hit(address_i, `FB_DIVISOR_ADDR)) begin
            if (byteenable_i[0]) begin
                mult_d[7:0] = wlo[7:0];
            end
            if (byteenable_i[1]) begin
                mult_d[8] = wlo[8];
            end
        end
        if (wr_hit && hit(address_i, `TUNING_ADDR) && byteenable_i[0]) begin
            trim_d = wlo[`TUNING_W-1:0];
        end
    end

    // Only power-on reset clears configuration; other_rst_n_i is not used here
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            recover_q  <= 1'b0;
            ratio_q    <= `CLK_DIV_RATIO_RST;
            ratio_en_q <= 1'b0;
            mult_q     <= `FB_DIV_MULT_RST;
            trim_q     <= `TUNING_RST;
        end else begin
            recover_q  <= recover_d;
            ratio_q    <= ratio_d;
            ratio_en_q <= ratio_en_d;
            mult_q     <= mult_d;
            trim_q     <= trim_d;
        end
    end

    // Bus: one wait cycle, answer at the second edge
    always_comb begin
        st_d    = st_q;
        rdata_d = rdata_q;
        case (st_q)
            BUS_IDLE: begin
                if (read_i || write_i) begin
                    st_d    = BUS_ACK;
                    rdata_d = 32'h0000_0000;
                    case (address_i)
                        `CLK_DIVISOR_ADDR: rdata_d[15:11] = {recover_q, ratio_q, ratio_en_q};
                        `FB_DIVISOR_ADDR:  rdata_d[8:0]   = mult_q;
                        `TUNING_ADDR:      rdata_d[5:0]   = trim_q;
                        `STATUS_ADDR:      rdata_d[1:0]   = {other_rst_n_i, ratio_en_q};
                        default:           rdata_d        = 32'h0000_0000;
                    endcase
                end
            end
            BUS_ACK: st_d = BUS_IDLE;
            default: st_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q    <= BUS_IDLE;
            rdata_q <= 32'h0000_0000;
        end else begin
            st_q    <= st_d;
            rdata_q <= rdata_d;
        end
    end

    assign waitrequest_o = !(st_q == BUS_ACK);
    assign readdata_o    = rdata_q;
    assign pll_mult_o    = mult_q;
    assign rc_osc_trim_o = trim_q;
    assign periph_tick_o = 1'b1;

    cpu_clk_div u_div (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (ratio_en_q),
        .sel_i      (ratio_q),
        .cpu_tick_o (cpu_tick_o)
    );

    // Clock divisor register rules
    AST_RECOVER_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        recover_q && irq_event_i |=> !ratio_en_q)
        else $error("ratio enable not cleared by interrupt");
    AST_SEL_LOCKED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ratio_en_q |=> ratio_q == $past(ratio_q))
        else $error("ratio select changed while enabled");
    AST_SEL_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_hit && address_i == `CLK_DIVISOR_ADDR && byteenable_i[1] && !ratio_en_q
        |=> ratio_q == $past(writedata_i[`CLK_DIV_RATIO_HI:`CLK_DIV_RATIO_LO]))
        else $error("ratio select write lost while disabled");
    AST_NO_EN_AT_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ratio_q == 3'h0 && !ratio_en_q |=> !ratio_en_q)
        else $error("enable set while select is zero");
    AST_EN_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_hit && address_i == `CLK_DIVISOR_ADDR && byteenable_i[1] && ratio_q != 3'h0
        && !(recover_q && irq_event_i) |=> ratio_en_q == $past(writedata_i[`CLK_DIV_EN_BIT]))
        else $error("ratio enable write lost");
    AST_DIVISOR_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q == BUS_IDLE && read_i && address_i == `CLK_DIVISOR_ADDR
        |=> readdata_o[31:16] == 16'h0000 && readdata_o[10:0] == 11'h000)
        else $error("divisor readback has stray bits");
    AST_POR_DIVISOR: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> ratio_q == `CLK_DIV_RATIO_RST && !recover_q && trim_q == `TUNING_RST)
        else $error("power-on divisor defaults wrong");

    // Feedback and tuning register rules
    AST_MULT_UPPER_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q == BUS_IDLE && read_i && address_i == `FB_DIVISOR_ADDR
        |=> readdata_o[31:9] == 23'h0 && readdata_o[8:0] == $past(mult_q))
        else $error("feedback readback wrong");
    AST_MULT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_hit && address_i == `FB_DIVISOR_ADDR && byteenable_i[1:0] == 2'h3
        |=> mult_q == $past(writedata_i[8:0]))
        else $error("feedback write lost");
    AST_TRIM_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_hit && address_i == `TUNING_ADDR && byteenable_i[0]
        |=> rc_osc_trim_o == $past(writedata_i[`TUNING_W-1:0]))
        else $error("trim write lost");
    AST_POR_DEFAULT: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> pll_mult_o == `FB_DIV_MULT_RST && !ratio_en_q)
        else $error("power-on defaults wrong");
    AST_OTHER_RST_KEEPS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !other_rst_n_i && !irq_event_i && !write_i |=> $stable(ratio_en_q) && $stable(mult_q))
        else $error("other reset changed config");

    // Bus protocol
    AST_BUS_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q == BUS_IDLE && (read_i || write_i) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer timing wrong");
    AST_STATUS_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q == BUS_IDLE && read_i && address_i == `STATUS_ADDR
        |=> readdata_o == {30'h0, $past(other_rst_n_i), $past(ratio_en_q)})
        else $error("status readback wrong");
    AST_UNMAPPED_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q == BUS_IDLE && read_i && address_i[1:0] != 2'h0
        |=> readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    COV_DOZE_ON: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !ratio_en_q ##1 ratio_en_q);
    COV_RECOVER_EXIT: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ratio_en_q && recover_q && irq_event_i ##1 !ratio_en_q);
    COV_MULT_WRITE: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $changed(mult_q));
    COV_SEL_LOCKED_WRITE: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_hit && address_i == `CLK_DIVISOR_ADDR && ratio_en_q);
    COV_OTHER_RESET: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !other_rst_n_i ##1 other_rst_n_i);
endmodule : clk_ctrl

// ---- dv/doze_and_pll_feedback_config_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module doze_and_pll_feedback_config_tb_top;
    logic        sys_clk_i     = 1'b0;
    logic        rst_n_i       = 1'b0;
    logic        other_rst_n_i = 1'b1;
    logic [3:0]  address_i     = 4'h0;
    logic        read_i        = 1'b0;
    logic        write_i       = 1'b0;
    logic [31:0] writedata_i   = 32'h0;
    logic [3:0]  byteenable_i  = 4'hF;
    logic        irq_event_i   = 1'b0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        cpu_tick_o;
    logic        periph_tick_o;
    logic [8:0]  pll_mult_o;
    logic [5:0]  rc_osc_trim_o;
    int          bad_count     = 0;
    int          n_tests       = 0;

    clk_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .other_rst_n_i(other_rst_n_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .irq_event_i(irq_event_i), .cpu_tick_o(cpu_tick_o), .periph_tick_o(periph_tick_o),
        .pll_mult_o(pll_mult_o), .rc_osc_trim_o(rc_osc_trim_o));

    always #10 sys_clk_i = ~sys_clk_i;

    // One Avalon access, held until waitrequest is seen low at a rising edge
    task acc(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        address_i   <= a;
        write_i     <= wr;
        read_i      <= !wr;
        writedata_i <= {16'h0, d};
        do @(posedge sys_clk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        write_i <= 1'b0;
        read_i  <= 1'b0;
    endtask : acc

    task wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    task rd_chk(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 16'h0, q);
        `CHK(n, e, q)
    endtask : rd_chk

    task reset_for(input int por);
        @(posedge sys_clk_i);
        if (por) rst_n_i <= 1'b0; else other_rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i       <= 1'b1;
        other_rst_n_i <= 1'b1;
    endtask : reset_for

    task count_ticks(input int e);
        int c;
        c = 0;
        repeat (3) @(posedge sys_clk_i);
        repeat (16) begin
            @(posedge sys_clk_i);
            c += int'(cpu_tick_o);
        end
        `CHK("cpu ticks", e, c)
        `CHK("periph tick", 1'b1, periph_tick_o)
    endtask : count_ticks

    task t_defaults;
        rd_chk("divisor", 4'h0, 32'h0000_3000);
        rd_chk("feedback", 4'h4, 32'h0000_0030);
        `CHK("mult out", 9'h030, pll_mult_o)
        count_ticks(16);
        $display("test defaults done");
    endtask : t_defaults

    task t_doze;
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0800);
        rd_chk("enable at sel 0", 4'h0, 32'h0000_0000);
        wr(4'h0, 16'h2000);
        wr(4'h0, 16'h2800);
        wr(4'h0, 16'h5800);
        rd_chk("sel locked", 4'h0, 32'h0000_2800);
        rd_chk("status on", 4'hC, 32'h0000_0003);
        count_ticks(4);
        $display("test doze done");
    endtask : t_doze

    task t_recover;
        wr(4'h0, 16'hA800);
        rd_chk("recover set", 4'h0, 32'h0000_A800);
        @(posedge sys_clk_i);
        irq_event_i <= 1'b1;
        @(posedge sys_clk_i);
        irq_event_i <= 1'b0;
        rd_chk("recover clears", 4'h0, 32'h0000_A000);
        rd_chk("status off", 4'hC, 32'h0000_0002);
        count_ticks(16);
        $display("test recover done");
    endtask : t_recover

    task t_mult;
        wr(4'h4, 16'hFFFF);
        rd_chk("mult max", 4'h4, 32'h0000_01FF);
        `CHK("mult out", 9'h1FF, pll_mult_o)
        // Lane 0 only: divisor write dropped, feedback bit 8 kept
        byteenable_i <= 4'h1;
        wr(4'h0, 16'h0000);
        wr(4'h4, 16'h0000);
        byteenable_i <= 4'hF;
        rd_chk("divisor lane0", 4'h0, 32'h0000_A000);
        rd_chk("mult lane0", 4'h4, 32'h0000_0100);
        wr(4'h8, 16'h00FF);
        rd_chk("trim", 4'h8, 32'h0000_003F);
        `CHK("trim out", 6'h3F, rc_osc_trim_o)
        rd_chk("unmapped", 4'h2, 32'h0000_0000);
        reset_for(0);
        rd_chk("mult kept", 4'h4, 32'h0000_0100);
        rd_chk("divisor kept", 4'h0, 32'h0000_A000);
        reset_for(1);
        rd_chk("mult por", 4'h4, 32'h0000_0030);
        rd_chk("divisor por", 4'h0, 32'h0000_3000);
        $display("test mult done");
    endtask : t_mult

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_defaults();
        t_doze();
        t_recover();
        t_mult();
        give_verdict();
    end
endmodule : doze_and_pll_feedback_config_tb_top
